/* common/tw_map.svh */
// Purpose: constants of the two-wire master receiver
// Assumes: 32-bit apb, byte-wide registers in low bits
// Notes: offsets are byte addresses
`ifndef TW_MAP_SVH
`define TW_MAP_SVH
`define TW_OFS_CTRL   8'h00
`define TW_OFS_STAT   8'h04
`define TW_OFS_DATA   8'h08
// control bit positions
`define TW_B_FLAG     7
`define TW_B_ACK      6
`define TW_B_STA      5
`define TW_B_STO      4
`define TW_B_WCOL     3
`define TW_B_EN       2
`define TW_B_IE       0
// status codes, prescaler bits zero
`define TW_S_START    8'h08
`define TW_S_RSTART   8'h10
`define TW_S_TXAACK   8'h18
`define TW_S_TXANAK   8'h20
`define TW_S_LOST     8'h38
`define TW_S_RXAACK   8'h40
`define TW_S_RXANAK   8'h48
`define TW_S_DACK     8'h50
`define TW_S_DNAK     8'h58
`define TW_S_NONE     8'hF8
// quarter bit time and clock period
`define TW_QTR_NS     2500
`define TW_CLK_PS     8000
`define TW_QTR_CYC    ((`TW_QTR_NS * 1000) / `TW_CLK_PS)
`define TW_LAST_BIT   4'h8
`endif

/* common/tw_pkg.sv */
// Purpose: types of the two-wire master receiver
// Assumes: constants come from tw_map.svh
// Notes: whole module state is one packed struct
`default_nettype none
package tw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_STOP, ST_HOLD, ST_LOST
  } tw_state_t;

  typedef struct packed {
    tw_state_t   st;
    logic [1:0]  q;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        ackbit;
    logic        addr_ph;
    logic        rxm;
    logic        rs;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        flag;
    logic        ack_en;
    logic        sta;
    logic        sto;
    logic        wcol;
    logic        en;
    logic        ie;
    logic [7:0]  code;
    logic [7:0]  data;
    logic        busy;
    logic        scl_m;
    logic        scl_s;
    logic        sda_m;
    logic        sda_s;
    logic        sda_p;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tw_regs_t;
endpackage
`default_nettype wire

/* rtl/tw_mrx.sv */
// Purpose: two-wire bus master receiver with apb registers
// Assumes: open-drain pins, pull-ups outside, apb master
// Notes: one quarter of a bus bit is QTR_CYC clocks
// What this block does
// - address direction bit picks receive or transmit
// - start request waits for idle bus
// - writing one to flag clears it, resumes
// - after START set flag, report 0x08
// - after read address report 0x38/0x40/0x48
// - received byte sits in data register
// - last wanted byte gets a not-acknowledge
// - from 0x40/0x50 receive next byte, ack per enable
// - stop request sends STOP, clears stop bit
// - start request after flag gives repeated START 0x10
// - both requests give STOP then START
// - write address at 0x10 goes transmit
// - lost arbitration reports 0x38, releases bus
// - unacknowledged read address reports 0x48, no data
// - byte acked gives 0x50, else 0x58
// - data write with flag low sets collision
`timescale 1ns/1ps
`default_nettype none
`include "tw_map.svh"
module tw_mrx #(
  parameter logic [15:0] QTR_CYC = 16'(`TW_QTR_CYC)
) (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe_n,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n
);
  tw_pkg::tw_regs_t r;
  tw_pkg::tw_regs_t nxt;
  logic             acc;
  logic             tick;
  logic             own;

  // apb access completes on the edge where pready is high
  assign acc  = i_psel & i_penable & r.pready;
  assign tick = (r.cnt == QTR_CYC - 16'h0001);
  // bits where a driven one can lose arbitration
  assign own  = r.addr_ph ? (r.bitn != `TW_LAST_BIT)
                          : (r.bitn == `TW_LAST_BIT);

  // next state of everything
  always_comb begin
    nxt = r;
    // two-flop synchronisers for the pins
    nxt.scl_m = i_scl;
    nxt.scl_s = r.scl_m;
    nxt.sda_m = i_sda;
    nxt.sda_s = r.sda_m;
    nxt.sda_p = r.sda_s;
    // bus busy from start and stop conditions seen on the wires
    if (r.scl_s && r.sda_p && !r.sda_s) begin
      nxt.busy = 1'b1;
    end
    if (r.scl_s && !r.sda_p && r.sda_s) begin
      nxt.busy = 1'b0;
    end
    // one wait state keeps every apb output a flop
    nxt.pready  = i_psel & i_penable & !r.pready;
    nxt.pslverr = 1'b0;
    nxt.prdata  = 32'h0000_0000;
    if (i_psel && i_penable && !r.pready) begin
      case (i_paddr)
        `TW_OFS_CTRL: nxt.prdata[7:0] = {r.flag, r.ack_en, r.sta, r.sto,
                                         r.wcol, r.en, 1'b0, r.ie};
        `TW_OFS_STAT: nxt.prdata[7:0] = r.code;
        `TW_OFS_DATA: nxt.prdata[7:0] = r.data;
        default:      nxt.pslverr     = 1'b1;
      endcase
    end
    // register writes; hardware sets below win over clears
    if (acc && i_pwrite) begin
      case (i_paddr)
        `TW_OFS_CTRL: begin
          nxt.ack_en = i_pwdata[`TW_B_ACK];
          nxt.sta    = i_pwdata[`TW_B_STA];
          nxt.sto    = i_pwdata[`TW_B_STO];
          nxt.en     = i_pwdata[`TW_B_EN];
          nxt.ie     = i_pwdata[`TW_B_IE];
          if (i_pwdata[`TW_B_FLAG]) begin
            nxt.flag = 1'b0;
          end
        end
        `TW_OFS_DATA: begin
          if (r.flag) begin
            nxt.data = i_pwdata[7:0];
            nxt.wcol = 1'b0;
          end else begin
            nxt.wcol = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // quarter-bit timer; in q1 it waits for a stretched clock
    if (r.st == tw_pkg::ST_IDLE || r.st == tw_pkg::ST_HOLD ||
        r.st == tw_pkg::ST_LOST) begin
      nxt.cnt = 16'h0000;
      nxt.q   = 2'h0;
    end else if (r.q == 2'h1 && !r.scl_s) begin
      nxt.cnt = 16'h0000;
    end else if (tick) begin
      nxt.cnt = 16'h0000;
      nxt.q   = r.q + 2'h1;
    end else begin
      nxt.cnt = r.cnt + 16'h0001;
    end
    // bus sequencer
    case (r.st)
      tw_pkg::ST_IDLE: begin
        nxt.scl_oe_n = 1'b1;
        nxt.sda_oe_n = 1'b1;
        if (r.en && r.sta && !r.busy && !r.flag) begin
          nxt.st = tw_pkg::ST_START;
          nxt.rs = 1'b0;
        end
      end
      tw_pkg::ST_START: begin
        case (r.q)
          2'h0: nxt.sda_oe_n = 1'b1;
          2'h1: nxt.scl_oe_n = 1'b1;
          2'h2: nxt.sda_oe_n = 1'b0;
          default: nxt.scl_oe_n = 1'b0;
        endcase
        if (tick && r.q == 2'h3) begin
          nxt.st   = tw_pkg::ST_HOLD;
          nxt.flag = 1'b1;
          nxt.code = r.rs ? `TW_S_RSTART : `TW_S_START;
        end
      end
      tw_pkg::ST_BIT: begin
        case (r.q)
          2'h0: begin
            nxt.scl_oe_n = 1'b0;
            if (r.addr_ph) begin
              nxt.sda_oe_n = (r.bitn == `TW_LAST_BIT) | r.sh[7];
            end else begin
              nxt.sda_oe_n = (r.bitn != `TW_LAST_BIT) | !r.ack_en;
            end
          end
          2'h1: nxt.scl_oe_n = 1'b1;
          default: nxt.scl_oe_n = (r.q != 2'h3);
        endcase
        if (tick && r.q == 2'h1) begin
          if (r.bitn == `TW_LAST_BIT) begin
            nxt.ackbit = r.sda_s;
          end else begin
            nxt.sh = {r.sh[6:0], r.sda_s};
          end
          if (own && r.sda_oe_n && !r.sda_s) begin
            nxt.st       = tw_pkg::ST_LOST;
            nxt.flag     = 1'b1;
            nxt.code     = `TW_S_LOST;
            nxt.scl_oe_n = 1'b1;
            nxt.sda_oe_n = 1'b1;
          end
        end
        if (tick && r.q == 2'h3) begin
          nxt.bitn = r.bitn + 4'h1;
          if (r.bitn == `TW_LAST_BIT) begin
            nxt.st       = tw_pkg::ST_HOLD;
            nxt.flag     = 1'b1;
            nxt.sda_oe_n = 1'b1;
            if (r.addr_ph && r.rxm) begin
              nxt.code = r.ackbit ? `TW_S_RXANAK : `TW_S_RXAACK;
            end else if (r.addr_ph) begin
              nxt.code = r.ackbit ? `TW_S_TXANAK : `TW_S_TXAACK;
            end else begin
              nxt.data = r.sh;
              nxt.code = r.ackbit ? `TW_S_DNAK : `TW_S_DACK;
            end
          end
        end
      end
      tw_pkg::ST_STOP: begin
        case (r.q)
          2'h0: begin
            nxt.scl_oe_n = 1'b0;
            nxt.sda_oe_n = 1'b0;
          end
          2'h1: nxt.scl_oe_n = 1'b1;
          default: nxt.sda_oe_n = 1'b1;
        endcase
        if (tick && r.q == 2'h3) begin
          nxt.sto = 1'b0;
          nxt.rs  = 1'b0;
          nxt.st  = r.sta ? tw_pkg::ST_START : tw_pkg::ST_IDLE;
        end
      end
      tw_pkg::ST_HOLD: begin
        nxt.scl_oe_n = 1'b0;
        if (!r.flag) begin
          nxt.bitn = 4'h0;
          if (r.sto) begin
            nxt.st = tw_pkg::ST_STOP;
          end else if (r.sta) begin
            nxt.st = tw_pkg::ST_START;
            nxt.rs = 1'b1;
          end else if (r.code == `TW_S_START ||
                       r.code == `TW_S_RSTART) begin
            nxt.st      = tw_pkg::ST_BIT;
            nxt.addr_ph = 1'b1;
            nxt.sh      = r.data;
            nxt.rxm     = r.data[0];
          end else if (r.code == `TW_S_RXAACK ||
                       r.code == `TW_S_DACK) begin
            nxt.st      = tw_pkg::ST_BIT;
            nxt.addr_ph = 1'b0;
          end
        end
      end
      tw_pkg::ST_LOST: begin
        nxt.scl_oe_n = 1'b1;
        nxt.sda_oe_n = 1'b1;
        if (!r.flag) begin
          nxt.st = tw_pkg::ST_IDLE;
        end
      end
      default: nxt.st = tw_pkg::ST_IDLE;
    endcase
    // disabled interface lets go of the bus at once
    if (!r.en) begin
      nxt.st       = tw_pkg::ST_IDLE;
      nxt.scl_oe_n = 1'b1;
      nxt.sda_oe_n = 1'b1;
    end
    // synchronous reset values
    if (i_sys_rst) begin
      nxt          = '0;
      nxt.st       = tw_pkg::ST_IDLE;
      nxt.scl_oe_n = 1'b1;
      nxt.sda_oe_n = 1'b1;
      nxt.scl_m    = 1'b1;
      nxt.scl_s    = 1'b1;
      nxt.sda_m    = 1'b1;
      nxt.sda_s    = 1'b1;
      nxt.sda_p    = 1'b1;
      nxt.code     = `TW_S_NONE;
    end
  end

  // the single state register
  always_ff @(posedge i_mclk) begin
    r <= nxt;
  end

  // outputs straight from flops, o_scl and o_sda tied low; open drain only pulls low
  assign o_prdata   = r.prdata;
  assign o_pready   = r.pready;
  assign o_pslverr  = r.pslverr;
  assign o_scl      = 1'b0;
  assign o_sda      = 1'b0;
  assign o_scl_oe_n = r.scl_oe_n;
  assign o_sda_oe_n = r.sda_oe_n;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_start_end;
    r.st == tw_pkg::ST_START && tick && r.q == 2'h3;
  endsequence
  sequence s_last_bit;
    r.st == tw_pkg::ST_BIT && tick && r.q == 2'h3 && r.bitn == `TW_LAST_BIT;
  endsequence
  sequence s_resume(logic [7:0] c);
    r.st == tw_pkg::ST_HOLD && !r.flag && !r.sto && !r.sta && r.code == c;
  endsequence

  a_hold_scl_low: assert property (
    r.st == tw_pkg::ST_HOLD |-> !r.scl_oe_n && r.flag || !r.flag)
    else $error("clock not held low with flag set");
  a_start_status: assert property (
    s_start_end ##0 !r.rs |=> r.flag && r.code == `TW_S_START)
    else $error("start did not report 0x08");
  a_rstart_status: assert property (
    s_start_end ##0 r.rs |=> r.flag && r.code == `TW_S_RSTART)
    else $error("repeated start did not report 0x10");
  a_addr_status: assert property (
    s_last_bit ##0 r.addr_ph && r.rxm |=> r.flag &&
      (r.code == `TW_S_RXAACK || r.code == `TW_S_RXANAK))
    else $error("bad status after read address");
  a_byte_status: assert property (
    s_last_bit ##0 !r.addr_ph |=> r.data == $past(r.sh) &&
      r.code == ($past(r.ackbit) ? `TW_S_DNAK : `TW_S_DACK))
    else $error("bad byte or status after reception");
  a_next_byte: assert property (
    s_resume(`TW_S_DACK) |=> r.st == tw_pkg::ST_BIT && !r.addr_ph)
    else $error("no reception after 0x50 resume");
  a_mode_pick: assert property (
    s_resume(`TW_S_START) ##0 r.en |=> r.addr_ph && r.rxm == $past(r.data[0]))
    else $error("direction bit not taken");
  a_wcol_set: assert property (
    acc && i_pwrite && i_paddr == `TW_OFS_DATA && !r.flag
      |=> r.wcol && (r.flag || $stable(r.data)))
    else $error("collision write not refused");
  a_stop_clear: assert property (
    r.st == tw_pkg::ST_STOP && tick && r.q == 2'h3 && r.en |=> !r.sto)
    else $error("stop bit not cleared");
  a_lost_free: assert property (
    r.st == tw_pkg::ST_LOST |-> r.scl_oe_n && r.sda_oe_n && r.code == `TW_S_LOST)
    else $error("bus kept after lost arbitration");
endmodule
`default_nettype wire

/* testbench/tw_slave_model.sv */
// Purpose: behavioural slave transmitter on the two-wire bus
// Assumes: open-drain lines, pull-ups in the bench
// Notes: bytes start at FIRST and step by 8'h11 on each ack
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A,
  parameter logic [7:0] FIRST = 8'hA5
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_slow,
  output logic      o_scl_oe_n,
  output logic      o_sda_oe_n
);
  logic       act  = 1'b0;
  logic       addr = 1'b0;
  logic       rd   = 1'b0;
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh   = 8'h00;
  logic [7:0] tx   = FIRST;
  initial begin
    o_scl_oe_n = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  // start and stop: data moves while clock high
  always @(negedge i_sda) if (i_scl) begin
    act = 1'b1;
    addr = 1'b1;
    bitn = 4'h0;
  end
  always @(posedge i_sda) if (i_scl) act = 1'b0;
  // sample on rising clock; ninth bit ends a byte
  always @(posedge i_scl) if (act) begin
    if (bitn == 4'h8) begin
      if (addr) act = rd & ~o_sda_oe_n;
      else if (i_sda) act = 1'b0;
      else tx = tx + 8'h11;
      addr = 1'b0;
      bitn = 4'h0;
    end else begin
      sh = {sh[6:0], i_sda};
      bitn = bitn + 4'h1;
    end
  end
  // change data only while clock low; optional stretch
  always @(negedge i_scl) begin
    if (!act) o_sda_oe_n = 1'b1;
    else if (addr) begin
      o_sda_oe_n = !(bitn == 4'h8 && sh[7:1] == ADDR);
      if (bitn == 4'h8) rd = sh[0];
    end else if (bitn == 4'h8) o_sda_oe_n = 1'b1;
    else o_sda_oe_n = tx[4'h7 - bitn];
    if (act && i_slow) begin
      o_scl_oe_n = 1'b0;
      #200 o_scl_oe_n = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* testbench/tw_mrx_tb.sv */
// Purpose: self-checking bench of the two-wire master receiver
// Assumes: slave model on the wires, pull-ups on both lines
// Notes: quarter bit of 4 clocks keeps the run short
`timescale 1ns/1ps
`default_nettype none
`include "tw_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tw_mrx_tb;
  logic        mclk  = 1'b0;
  logic        rst   = 1'b1;
  logic        psel  = 1'b0;
  logic        pen   = 1'b0;
  logic        pwr   = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwd   = 32'h0000_0000;
  logic        slow  = 1'b0;
  logic        jam   = 1'b0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic        prdy;
  logic        perr;
  logic        err;
  int          num_errors = 0;
  int          checks = 0;
  wire logic   scl_oe_n, sda_oe_n, s_scl_oe_n, s_sda_oe_n, m_scl, m_sda;
  // wired-and with pull-ups; jam is a rival master holding data low
  wire logic   scl = (scl_oe_n | m_scl) & s_scl_oe_n;
  wire logic   sda = (sda_oe_n | m_sda) & s_sda_oe_n & ~jam;

  tw_mrx #(.QTR_CYC(16'h0004)) i_tw_mrx (
    .i_mclk(mclk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_scl(scl), .o_scl(m_scl), .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(m_sda),
    .o_sda_oe_n(sda_oe_n));
  tw_slave_model i_tw_slave_model (
    .i_scl(scl), .i_sda(sda), .i_slow(slow), .o_scl_oe_n(s_scl_oe_n),
    .o_sda_oe_n(s_sda_oe_n));

  initial forever #4 mclk = ~mclk;

  task automatic final_report();
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one apb transfer; read data taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, `TW_OFS_CTRL, d);
  endtask
  // poll a control bit, bounded
  task automatic wait_ctl(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `TW_OFS_CTRL, 32'h0000_0000);
      n++;
    end while (rd[b] !== v && n < 300);
    if (n >= 300) begin
      num_errors++;
      final_report();
    end
  endtask
  // prescaler bits masked before comparing
  task automatic stat(input logic [7:0] e);
    apb(1'b0, `TW_OFS_STAT, 32'h0000_0000);
    `CHK(rd[7:0] & 8'hF8, e)
  endtask
  task automatic dchk(input logic [7:0] e);
    apb(1'b0, `TW_OFS_DATA, 32'h0000_0000);
    `CHK(rd[7:0], e)
  endtask

  task automatic t_regs();
    apb(1'b0, `TW_OFS_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    stat(8'hF8);
    dchk(8'h00);
    ctl(32'h0000_0001);
    apb(1'b0, `TW_OFS_CTRL, 32'h0000_0000);
    `CHK(rd[7:0], 8'h01)
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask
  task automatic t_wcol();
    ctl(32'h0000_0004);
    apb(1'b1, `TW_OFS_DATA, 32'h0000_0055);
    apb(1'b0, `TW_OFS_CTRL, 32'h0000_0000);
    `CHK(rd[3], 1'b1)
    dchk(8'h00);
  endtask
  task automatic t_read();
    int n;
    ctl(32'h0000_00A4);
    wait_ctl(7, 1'b1);
    stat(8'h08);
    `CHK(scl, 1'b0)
    apb(1'b1, `TW_OFS_DATA, 32'h0000_0055);
    ctl(32'h0000_0084);
    apb(1'b0, `TW_OFS_CTRL, 32'h0000_0000);
    `CHK(rd[7], 1'b0)
    wait_ctl(7, 1'b1);
    stat(8'h40);
    ctl(32'h0000_00C4);
    wait_ctl(7, 1'b1);
    stat(8'h50);
    dchk(8'hA5);
    ctl(32'h0000_0084);
    wait_ctl(7, 1'b1);
    stat(8'h58);
    dchk(8'hB6);
    ctl(32'h0000_00A4);
    wait_ctl(7, 1'b1);
    stat(8'h10);
    apb(1'b1, `TW_OFS_DATA, 32'h0000_0057);
    ctl(32'h0000_0084);
    wait_ctl(7, 1'b1);
    stat(8'h48);
    ctl(32'h0000_0094);
    wait_ctl(4, 1'b0);
    n = 0;
    while ({scl, sda} !== 2'b11 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n < 100, 1'b1)
  endtask
  // slave stretches the clock here
  task automatic t_write();
    slow <= 1'b1;
    ctl(32'h0000_00A4);
    wait_ctl(7, 1'b1);
    stat(8'h08);
    apb(1'b1, `TW_OFS_DATA, 32'h0000_0054);
    ctl(32'h0000_0084);
    wait_ctl(7, 1'b1);
    stat(8'h18);
    ctl(32'h0000_00A4);
    wait_ctl(7, 1'b1);
    stat(8'h10);
    apb(1'b1, `TW_OFS_DATA, 32'h0000_0054);
    ctl(32'h0000_0084);
    wait_ctl(7, 1'b1);
    stat(8'h18);
    // no stretch on the last start, so release below is clean
    slow <= 1'b0;
    ctl(32'h0000_00B4);
    wait_ctl(7, 1'b1);
    stat(8'h08);
    apb(1'b0, `TW_OFS_CTRL, 32'h0000_0000);
    `CHK(rd[4], 1'b0)
    ctl(32'h0000_0000);
  endtask

  // a rival master holds data low, second address bit is lost
  task automatic t_lost();
    ctl(32'h0000_00A4);
    wait_ctl(7, 1'b1);
    apb(1'b1, `TW_OFS_DATA, 32'h0000_0055);
    jam <= 1'b1;
    ctl(32'h0000_0084);
    wait_ctl(7, 1'b1);
    stat(8'h38);
    `CHK(scl, 1'b1)
    jam <= 1'b0;
    ctl(32'h0000_0084);
    `CHK(sda, 1'b1)
  endtask
  // reset in mid-run brings registers back
  task automatic t_rst();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    stat(8'hF8);
    dchk(8'h00);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_wcol();
    t_read();
    t_write();
    t_lost();
    t_rst();
    final_report();
  end
endmodule
`default_nettype wire
